/* multiplexed_display_and_switch_scan.v */
`timescale 1ns/1ns
`include "multiplexed_scan_defs.vh"

// Overview of operation
// - Control 000-007; bit two selects eight digits
// - Eight digits use two words, upper second
// - Idle when disabled or in error; else drive source digits
// - Full refresh every twelve steps, then repeat
// - Four shared data lines (eight with eight digits), one latch per digit position
// - Bits 0-3 data, bits 4-7 latches
// - Round done on bit 12 or 8
// - Both sequences restart at step zero on reset
// - Display busy flag high while executing
// - Error on bad code or split areas
// - Switch reader fills two result words
// - Switch reading completes in twenty steps
// - Switch reader uses six outputs, eight inputs
// - Switch output 5 marks round complete
// - Switch busy flag high while executing

module multiplexed_display_and_switch_scan
(
  input wire mclk_in,
  input wire rst_in,
  input wire [2:0] reg_addr_in,
  input wire [15:0] reg_wdata_in,
  input wire reg_wr_in,
  input wire reg_rd_in,
  output wire [15:0] reg_rdata_out,
  output wire [15:0] display_word_out,
  input wire [7:0] switch_input_word_in,
  output wire [5:0] switch_output_word_out,
  output wire display_busy_flag_out,
  output wire switch_busy_flag_out,
  output wire error_flag_out
);

  // ==========================================================
  // Registers
  reg [15:0] ctrl_ff;
  reg [15:0] src_lo_ff;
  reg [15:0] src_hi_ff;
  reg [15:0] area_ff;
  reg [15:0] rdata_ff;
  reg [15:0] disp_word_ff;
  reg [1:0] digit_ff;
  reg [1:0] phase_ff;
  reg [15:0] nxt_word;
  reg [15:0] nxt_rdata;

  wire [7:0] code = ctrl_ff[`MS_CTRL_CODE_MSB:`MS_CTRL_CODE_LSB];
  wire disp_en = ctrl_ff[`MS_CTRL_DISP_EN];
  wire sw_en = ctrl_ff[`MS_CTRL_SW_EN];
  wire eight = code[`MS_CODE_EIGHT];
  wire data_inv = code[`MS_CODE_DATA_INV];
  wire latch_inv = code[`MS_CODE_LATCH_INV];

  wire [1:0] src_lo_area = area_ff[`MS_AREA_SRC_LO_LSB+1:`MS_AREA_SRC_LO_LSB];
  wire [1:0] src_hi_area = area_ff[`MS_AREA_SRC_HI_LSB+1:`MS_AREA_SRC_HI_LSB];
  wire [1:0] res_lo_area = area_ff[`MS_AREA_RES_LO_LSB+1:`MS_AREA_RES_LO_LSB];
  wire [1:0] res_hi_area = area_ff[`MS_AREA_RES_HI_LSB+1:`MS_AREA_RES_HI_LSB];

  // ==========================================================
  // Operand checks
  wire code_bad = (code > `MS_CODE_MAX);
  wire src_split = eight && (src_lo_area != src_hi_area);
  wire disp_err = code_bad || src_split;
  wire res_split = (res_lo_area != res_hi_area);
  wire disp_run = disp_en && !disp_err;
  wire sw_run = sw_en && !res_split;

  // ==========================================================
  // Display step counter: four digits, three phases each
  wire last_phase = (phase_ff == 2'd`MS_DISP_PHASES - 2'd1);
  wire last_step = last_phase && (digit_ff == 2'h3);

  always @(posedge mclk_in)
  begin
    if (rst_in)
    begin
      digit_ff <= 2'h0;
      phase_ff <= 2'h0;
    end
    else if (disp_run)
    begin
      if (last_phase)
      begin
        phase_ff <= 2'h0;
        digit_ff <= digit_ff + 2'h1;
      end
      else
        phase_ff <= phase_ff + 2'h1;
    end
  end

  // ==========================================================
  // Digit selection
  wire [15:0] sh_lo = src_lo_ff >> {digit_ff, 2'b00};
  wire [15:0] sh_hi = src_hi_ff >> {digit_ff, 2'b00};
  wire [3:0] dig_lo = sh_lo[3:0];
  wire [3:0] dig_hi = sh_hi[3:0];
  wire [3:0] strobe_onehot = 4'h1 << digit_ff;

  // ==========================================================
  // Display word composition
  always @*
  begin
    nxt_word = 16'h0000;
    // Data on lines from phase 0, held through the strobe and after
    nxt_word[3:0] = dig_lo ^ {4{data_inv}};
    if (phase_ff == 2'h1)
      nxt_word[7:4] = strobe_onehot ^ {4{latch_inv}};
    else
      nxt_word[7:4] = {4{latch_inv}};
    if (eight)
    begin
      nxt_word[11:8] = dig_hi ^ {4{data_inv}};
      nxt_word[`MS_DISP_DONE8] = last_step;
    end
    else
      nxt_word[`MS_DISP_DONE4] = last_step;
  end

  always @(posedge mclk_in)
  begin
    if (rst_in)
      disp_word_ff <= 16'h0000;
    else if (disp_run)
      disp_word_ff <= nxt_word;
  end

  // ==========================================================
  // Switch reader
  wire [15:0] res_lo;
  wire [15:0] res_hi;
  wire sw_busy;
  wire sw_done;

  thumbwheel_reader u_reader
  (
    .mclk_in(mclk_in),
    .rst_in(rst_in),
    .run_in(sw_run),
    .switch_input_word_in(switch_input_word_in),
    .switch_output_word_out(switch_output_word_out),
    .result_lo_out(res_lo),
    .result_hi_out(res_hi),
    .busy_out(sw_busy),
    .done_out(sw_done)
  );

  // ==========================================================
  // Register writes
  always @(posedge mclk_in)
  begin
    if (rst_in)
    begin
      ctrl_ff <= `MS_CTRL_RESET;
      src_lo_ff <= 16'h0000;
      src_hi_ff <= 16'h0000;
      area_ff <= `MS_AREA_RESET;
    end
    else if (reg_wr_in)
    begin
      if (reg_addr_in == `MS_ADDR_CTRL)
        ctrl_ff <= {6'h00, reg_wdata_in[9:0]};
      else if (reg_addr_in == `MS_ADDR_SRC_LO)
        src_lo_ff <= reg_wdata_in;
      else if (reg_addr_in == `MS_ADDR_SRC_HI)
        src_hi_ff <= reg_wdata_in;
      else if (reg_addr_in == `MS_ADDR_AREA)
        area_ff <= {8'h00, reg_wdata_in[7:0]};
    end
  end

  // ==========================================================
  // Register reads, data one cycle later
  wire disp_done = eight ? disp_word_ff[`MS_DISP_DONE8] : disp_word_ff[`MS_DISP_DONE4];

  always @*
  begin
    nxt_rdata = 16'h0000;
    if (reg_addr_in == `MS_ADDR_CTRL)
      nxt_rdata = ctrl_ff;
    else if (reg_addr_in == `MS_ADDR_SRC_LO)
      nxt_rdata = src_lo_ff;
    else if (reg_addr_in == `MS_ADDR_SRC_HI)
      nxt_rdata = src_hi_ff;
    else if (reg_addr_in == `MS_ADDR_STATUS)
    begin
      nxt_rdata[`MS_STAT_DISP_BUSY] = disp_run;
      nxt_rdata[`MS_STAT_SW_BUSY] = sw_busy;
      nxt_rdata[`MS_STAT_ERROR] = error_flag_out;
      nxt_rdata[`MS_STAT_DISP_DONE] = disp_done;
      nxt_rdata[`MS_STAT_SW_DONE] = sw_done;
    end
    else if (reg_addr_in == `MS_ADDR_RES_LO)
      nxt_rdata = res_lo;
    else if (reg_addr_in == `MS_ADDR_RES_HI)
      nxt_rdata = res_hi;
    else if (reg_addr_in == `MS_ADDR_AREA)
      nxt_rdata = area_ff;
  end

  always @(posedge mclk_in)
  begin
    if (rst_in)
      rdata_ff <= 16'h0000;
    else if (reg_rd_in)
      rdata_ff <= nxt_rdata;
    else
      rdata_ff <= 16'h0000;
  end

  // ==========================================================
  // Outputs
  assign reg_rdata_out = rdata_ff;
  assign display_word_out = disp_word_ff;
  assign display_busy_flag_out = disp_run;
  assign switch_busy_flag_out = sw_busy;
  assign error_flag_out = (disp_en && disp_err) || (sw_en && res_split);

endmodule

/* multiplexed_scan_defs.vh */
`ifndef MULTIPLEXED_SCAN_DEFS_VH
`define MULTIPLEXED_SCAN_DEFS_VH

// ==========================================================
// Register offsets
`define MS_ADDR_CTRL 3'h0
`define MS_ADDR_SRC_LO 3'h1
`define MS_ADDR_SRC_HI 3'h2
`define MS_ADDR_STATUS 3'h3
`define MS_ADDR_RES_LO 3'h4
`define MS_ADDR_RES_HI 3'h5
`define MS_ADDR_AREA 3'h6

// ==========================================================
// Control register fields
`define MS_CTRL_CODE_LSB 0
`define MS_CTRL_CODE_MSB 7
`define MS_CTRL_DISP_EN 8
`define MS_CTRL_SW_EN 9
`define MS_CTRL_RESET 16'h0000

// Control code fields and limits
`define MS_CODE_LATCH_INV 0
`define MS_CODE_DATA_INV 1
`define MS_CODE_EIGHT 2
`define MS_CODE_MAX 8'h07

// ==========================================================
// Area register fields
`define MS_AREA_SRC_LO_LSB 0
`define MS_AREA_SRC_HI_LSB 2
`define MS_AREA_RES_LO_LSB 4
`define MS_AREA_RES_HI_LSB 6
`define MS_AREA_RESET 16'h0000

// ==========================================================
// Status register fields
`define MS_STAT_DISP_BUSY 0
`define MS_STAT_SW_BUSY 1
`define MS_STAT_ERROR 2
`define MS_STAT_DISP_DONE 3
`define MS_STAT_SW_DONE 4

// ==========================================================
// Display output word fields
`define MS_DISP_DONE8 12
`define MS_DISP_DONE4 8

// Switch output word fields
`define MS_SW_LATCH_BIT 4
`define MS_SW_DONE_BIT 5

// ==========================================================
// Sequence lengths in scan steps
`define MS_DISP_STEPS 12
`define MS_DISP_PHASES 3
`define MS_SW_STEPS 20
`define MS_SW_FIRST_SEL 2
`define MS_SW_COMMIT 18
`define MS_SW_DONE_STEP 19

`endif

/* thumbwheel_reader.v */
`timescale 1ns/1ns
`include "multiplexed_scan_defs.vh"

module thumbwheel_reader
(
  input wire mclk_in,
  input wire rst_in,
  input wire run_in,
  input wire [7:0] switch_input_word_in,
  output wire [5:0] switch_output_word_out,
  output wire [15:0] result_lo_out,
  output wire [15:0] result_hi_out,
  output wire busy_out,
  output wire done_out
);

  reg [4:0] step_ff;
  reg [5:0] word_ff;
  reg [15:0] acc_lo_ff;
  reg [15:0] acc_hi_ff;
  reg [15:0] res_lo_ff;
  reg [15:0] res_hi_ff;
  reg [5:0] nxt_word;
  wire [15:0] nxt_acc_lo;
  wire [15:0] nxt_acc_hi;
  wire [3:0] sw_lo = switch_input_word_in[3:0];
  wire [3:0] sw_hi = switch_input_word_in[7:4];

  wire [4:0] rel = step_ff - 5'h02;
  wire [1:0] pair = rel[3:2];
  wire [1:0] phase = rel[1:0];
  wire in_sel = (step_ff >= 5'd`MS_SW_FIRST_SEL) && (step_ff < 5'd`MS_SW_COMMIT);
  wire sample = run_in && in_sel && (phase == 2'h1);

  // ==========================================================
  // Step counter
  always @(posedge mclk_in)
  begin
    if (rst_in)
      step_ff <= 5'h00;
    else if (run_in)
    begin
      if (step_ff == 5'd`MS_SW_DONE_STEP)
        step_ff <= 5'h00;
      else
        step_ff <= step_ff + 5'h01;
    end
  end

  // ==========================================================
  // Output word: latch, per-digit-pair read select, round done
  always @*
  begin
    nxt_word = 6'h00;
    if (step_ff < 5'd`MS_SW_FIRST_SEL)
      nxt_word[`MS_SW_LATCH_BIT] = 1'b1;
    if (in_sel && (phase != 2'h3))
      nxt_word[pair] = 1'b1;
    if (step_ff == 5'd`MS_SW_DONE_STEP)
      nxt_word[`MS_SW_DONE_BIT] = 1'b1;
  end

  always @(posedge mclk_in)
  begin
    if (rst_in)
      word_ff <= 6'h00;
    else if (run_in)
      word_ff <= nxt_word;
  end

  // ==========================================================
  // Nibble capture, one entry per digit pair
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1)
    begin : g_nib
      localparam [1:0] IDX = g;
      wire take = sample && (pair == IDX);
      assign nxt_acc_lo[g*4+3:g*4] = take ? sw_lo : acc_lo_ff[g*4+3:g*4];
      assign nxt_acc_hi[g*4+3:g*4] = take ? sw_hi : acc_hi_ff[g*4+3:g*4];
    end
  endgenerate

  always @(posedge mclk_in)
  begin
    if (rst_in)
    begin
      acc_lo_ff <= 16'h0000;
      acc_hi_ff <= 16'h0000;
    end
    else
    begin
      acc_lo_ff <= nxt_acc_lo;
      acc_hi_ff <= nxt_acc_hi;
    end
  end

  // ==========================================================
  // Result commit once all digits are in
  always @(posedge mclk_in)
  begin
    if (rst_in)
    begin
      res_lo_ff <= 16'h0000;
      res_hi_ff <= 16'h0000;
    end
    else if (run_in && (step_ff == 5'd`MS_SW_COMMIT))
    begin
      res_lo_ff <= acc_lo_ff;
      res_hi_ff <= acc_hi_ff;
    end
  end

  assign switch_output_word_out = word_ff;
  assign result_lo_out = res_lo_ff;
  assign result_hi_out = res_hi_ff;
  assign busy_out = run_in;
  assign done_out = word_ff[`MS_SW_DONE_BIT];

endmodule

/* scan_partner.sv */
`timescale 1ns/1ns
// ====================
// Display latches and thumbwheel switch
module scan_partner
(
  input wire mclk_in,
  input wire rst_in,
  input wire [1:0] code_in,
  input wire [15:0] display_word_in,
  input wire [5:0] switch_output_word_in,
  input wire [31:0] set_value_in,
  output logic [7:0] switch_input_word_out,
  output logic [31:0] shown_out
);
  logic [31:0] held_ff = 32'h0;
  logic [7:0] last_ff = 8'h0;
  wire [3:0] strb = display_word_in[7:4] ^ {4{code_in[0]}};
  wire [3:0] inv = {4{code_in[1]}};
  always @(posedge mclk_in)
  begin
    if (rst_in)
      shown_out <= 32'h0;
    else
      for (int k = 0; k < 4; k++)
        if (strb[k])
          {shown_out[16+4*k +: 4], shown_out[4*k +: 4]} <=
            {display_word_in[11:8], display_word_in[3:0]} ^ {inv, inv};
    if (switch_output_word_in[4])
      held_ff <= set_value_in;
    last_ff <= switch_input_word_out;
  end
  always_comb
  begin
    switch_input_word_out = ~last_ff;
    for (int k = 0; k < 4; k++)
      if (switch_output_word_in[k])
        switch_input_word_out = {held_ff[16+4*k +: 4], held_ff[4*k +: 4]};
  end
endmodule

/* scan_chk.sv */
`timescale 1ns/1ns
// ====================
// Port checker
module scan_chk
(
  input wire mclk_in,
  input wire rst_in,
  input wire reg_wr_in,
  input wire [15:0] display_word_out,
  input wire [5:0] switch_output_word_out,
  input wire display_busy_flag_out,
  input wire switch_busy_flag_out,
  input wire error_flag_out
);
  wire [15:0] dw = display_word_out;
  wire [5:0] sw = switch_output_word_out;
  wire db = display_busy_flag_out;
  wire sb = switch_busy_flag_out;
  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (rst_in);
  a_err_idle: assert property (error_flag_out |-> !(db && sb))
    else $error("both sides busy beside error");
  a_disp_freeze: assert property (!db |=> $stable(dw))
    else $error("display word moved while idle");
  a_strobe_hold: assert property ($countones(dw[7:4]) inside {1, 3} |->
    $stable(dw[3:0]) ##1 $stable(dw[3:0])) else $error("data moved around strobe");
  a_done_gap: assert property (dw[12] && db |=> !dw[12] [*8])
    else $error("round done too soon");
  a_sw_freeze: assert property (!sb |=> $stable(sw))
    else $error("switch word moved while idle");
  a_sw_onehot: assert property ($onehot0(sw))
    else $error("switch outputs overlap");
  a_sw_select: assert property ($rose(sw[0]) ##0 sb [*3] |-> sw[0] ##1 !sw[0])
    else $error("select length wrong");
  a_sw_wrap: assert property (sw[5] && sb |=> sw[4] ##1 sw[4] ##1 !sw[4])
    else $error("switch round wrap wrong");
  a_flag_hold: assert property (!reg_wr_in |=> $stable({db, sb, error_flag_out}))
    else $error("flag moved without write");
  c_disp_done: cover property (dw[12] && db);
  c_sw_done: cover property (sw[5] && sb);
  c_error: cover property (error_flag_out);
endmodule
bind multiplexed_display_and_switch_scan scan_chk chk (.mclk_in(mclk_in), .rst_in(rst_in),
  .reg_wr_in(reg_wr_in), .display_word_out(display_word_out),
  .switch_output_word_out(switch_output_word_out), .display_busy_flag_out(display_busy_flag_out),
  .switch_busy_flag_out(switch_busy_flag_out), .error_flag_out(error_flag_out));

/* tb_multiplexed_display_and_switch_scan.sv */
`timescale 1ns/1ns
// ====================
// Bench
module tb_multiplexed_display_and_switch_scan;
  typedef struct {logic [7:0] code; logic [15:0] lo; logic [15:0] hi; logic [3:0] bit_;} row_t;
  logic mclk_in = 1'b0;
  logic rst_in = 1'b1;
  logic [2:0] reg_addr = 3'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [1:0] pcode = 2'h0;
  logic [31:0] setv = 32'h0;
  logic [15:0] rdata, dw, hold, m;
  logic [7:0] swi;
  logic [5:0] swo;
  logic db, sb, ef;
  logic [31:0] shown;
  int n_mismatch = 0;
  int check_count = 0;
  int n;
  row_t rows [8] = '{'{8'h00, 16'h4321, 16'h8765, 4'h8}, '{8'h01, 16'h9078, 16'h1111, 4'h8},
    '{8'h02, 16'h5031, 16'h2222, 4'h8}, '{8'h03, 16'h0259, 16'h3333, 4'h8},
    '{8'h04, 16'h4321, 16'h8765, 4'hC}, '{8'h05, 16'h1357, 16'h2468, 4'hC},
    '{8'h06, 16'h9081, 16'h7263, 4'hC}, '{8'h07, 16'h0909, 16'h9090, 4'hC}};
  multiplexed_display_and_switch_scan uut
  (
    .mclk_in(mclk_in), .rst_in(rst_in), .reg_addr_in(reg_addr), .reg_wdata_in(reg_wdata),
    .reg_wr_in(reg_wr), .reg_rd_in(reg_rd), .reg_rdata_out(rdata), .display_word_out(dw),
    .switch_input_word_in(swi), .switch_output_word_out(swo), .display_busy_flag_out(db),
    .switch_busy_flag_out(sb), .error_flag_out(ef)
  );
  scan_partner far
  (
    .mclk_in(mclk_in), .rst_in(rst_in), .code_in(pcode), .display_word_in(dw),
    .switch_output_word_in(swo), .set_value_in(setv), .switch_input_word_out(swi),
    .shown_out(shown)
  );
  initial
  begin
    forever #20 mclk_in = ~mclk_in;
  end
  // ====================
  // Tasks
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic do_reset();
    @(posedge mclk_in);
    rst_in <= 1'b1;
    repeat (10) @(posedge mclk_in);
    rst_in <= 1'b0;
  endtask
  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    @(posedge mclk_in);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk_in);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] a, input logic [15:0] exp, input string nm);
    @(posedge mclk_in);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk_in);
    reg_rd <= 1'b0;
    @(negedge mclk_in);
    chk(nm, exp, rdata);
  endtask
  task automatic mark(input logic [3:0] b, input logic s, output int cnt);
    cnt = 0;
    do
    begin
      @(negedge mclk_in);
      cnt++;
    end
    while ((s ? swo[5] : dw[b]) !== 1'b1 && cnt < 40);
  endtask
  task automatic err_case(input logic [15:0] area, input logic [15:0] ctrl, input logic [2:0] e);
    wr(3'h6, area);
    wr(3'h0, ctrl);
    @(negedge mclk_in);
    chk("flags", e, {ef, db, sb});
    rd(3'h3, {13'h0000, e[2], e[0], e[1]}, "status");
  endtask
  task automatic results();
    $display("Checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // ====================
  // Sequence
  initial
  begin
    do_reset();
    rd(3'h0, 16'h0000, "ctrl");
    rd(3'h6, 16'h0000, "area");
    rd(3'h7, 16'h0000, "unmapped");
    chk("idle words", 32'h0, {dw, swo});
    for (int i = 0; i < 8; i++)
    begin
      do_reset();
      pcode <= rows[i].code[1:0];
      m = rows[i].code[2] ? 16'hFFFF : 16'h0000;
      wr(3'h1, rows[i].lo);
      wr(3'h2, rows[i].hi);
      wr(3'h0, {8'h01, rows[i].code});
      mark(rows[i].bit_, 1'b0, n);
      chk("first round", 13, n);
      mark(rows[i].bit_, 1'b0, n);
      chk("round", 12, n);
      chk("digits lo", rows[i].lo, shown[15:0]);
      chk("digits hi", rows[i].hi & m, shown[31:16] & m);
      chk("disp busy", 1, db);
    end
    repeat (11) @(posedge mclk_in);
    rd(3'h3, 16'h0009, "disp status");
    wr(3'h0, 16'h0000);
    @(negedge mclk_in);
    hold = dw;
    repeat (5) @(negedge mclk_in);
    chk("frozen word", hold, dw);
    do_reset();
    err_case(16'h0000, 16'h0108, 3'b100);
    err_case(16'h0004, 16'h0104, 3'b100);
    err_case(16'h0004, 16'h0300, 3'b011);
    err_case(16'h0040, 16'h0200, 3'b100);
    do_reset();
    setv <= 32'h87654321;
    wr(3'h0, 16'h0200);
    mark(4'h0, 1'b1, n);
    chk("sw first round", 21, n);
    mark(4'h0, 1'b1, n);
    chk("sw round", 20, n);
    chk("sw busy", 1, sb);
    repeat (19) @(posedge mclk_in);
    rd(3'h3, 16'h0012, "sw status");
    rd(3'h4, 16'h4321, "result lo");
    rd(3'h5, 16'h8765, "result hi");
    results();
  end
  initial
  begin
    repeat (5000) @(posedge mclk_in);
    n_mismatch++;
    results();
  end
endmodule
